// >>> logic/pio_pkg.sv
// pio_pkg: register addresses, reset values and sizes for the port block
// assumes an 8-bit special-function-register bus with byte and bit access
package pio_pkg;
  localparam int PIO_PORTS = 3;
  localparam int PIO_PINS = 24;
  localparam logic [7:0] PIO_ADDR_P0_LATCH = 8'h80;
  localparam logic [7:0] PIO_ADDR_P1_LATCH = 8'h90;
  localparam logic [7:0] PIO_ADDR_P2_LATCH = 8'hA0;
  localparam logic [7:0] PIO_ADDR_P0_DRIVE = 8'hA4;
  localparam logic [7:0] PIO_ADDR_P1_DRIVE = 8'hA5;
  localparam logic [7:0] PIO_ADDR_P2_DRIVE = 8'hA6;
  localparam logic [7:0] PIO_ADDR_P0_OVRD = 8'hB0;
  localparam logic [7:0] PIO_ADDR_P0_MASK = 8'hC7;
  localparam logic [7:0] PIO_ADDR_P1_MASK = 8'hCD;
  localparam logic [7:0] PIO_ADDR_P1_VALUE = 8'hCE;
  localparam logic [7:0] PIO_ADDR_P0_SKIP = 8'hD4;
  localparam logic [7:0] PIO_ADDR_P1_SKIP = 8'hD5;
  localparam logic [7:0] PIO_ADDR_P2_SKIP = 8'hD6;
  localparam logic [7:0] PIO_ADDR_P0_VALUE = 8'hD7;
  localparam logic [7:0] PIO_ADDR_P0_KIND = 8'hF1;
  localparam logic [7:0] PIO_ADDR_P1_KIND = 8'hF2;
  localparam logic [7:0] PIO_ADDR_P2_KIND = 8'hF3;
  localparam logic [7:0] PIO_RST_LATCH = 8'hFF;
  localparam logic [7:0] PIO_RST_DRIVE = 8'h00;
  localparam logic [7:0] PIO_RST_OVRD = 8'h00;
  localparam logic [7:0] PIO_RST_MASK = 8'h00;
  localparam logic [7:0] PIO_RST_SKIP = 8'h00;
  localparam logic [7:0] PIO_RST_VALUE = 8'hFF;
  localparam logic [7:0] PIO_RST_KIND = 8'hFF;
endpackage

// >>> logic/pio_port.sv
// pio_port: three 8-bit ports with latches, pin readback, drive modes and match detect
// assumes pins arrive asynchronously; bus, crossbar and control inputs share clk
// Notes on behaviour
// - unclaimed digital pins are driven from their latch bit
// - port latches take byte writes and single-bit writes
// - a write stores into the latch, held until rewritten
// - a plain read returns pin levels, even for crossbar-claimed pins
// - read-modify-write reads return the latch, not the pins
// - latch 0 drives low; 1 drives high, or floats when open-drain
// - analog pins read 0; digital pins read their level
// - input kind 0 makes pin analog: no pullup, driver, receiver
// - drive type 0 open-drain, 1 push-pull; ignored for analog pins
// - pins carrying I2C signals are always open-drain
// - bypass bit 1 makes the crossbar skip that pin
// - ports 0 and 1 flag match when masked pins differ from value
// - mask bit 0 excludes the pin from comparison
// - match raises interrupt when enabled, and always wakes the oscillator
// - port 0 overdrive bit selects normal or high-impedance overdrive
// - crossbar off disables all output drivers
// - weak pullup on open-drain pins unless disabled, driving low or analog
`timescale 1ns/10ps
module pio_port
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_num,
  input wire logic sfr_bit_val,
  input wire logic sfr_rd,
  input wire logic sfr_rmw,
  output logic [7:0] sfr_rdata,
  input wire logic crossbar_on,
  input wire logic pullup_disable,
  input wire logic match_irq_enable,
  input wire logic [23:0] xbar_claim,
  input wire logic [23:0] xbar_data,
  input wire logic [23:0] i2c_route,
  input wire logic [23:0] pin_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  output logic [23:0] pin_pullup,
  output logic [23:0] pin_digital,
  output logic [23:0] crossbar_bypass,
  output logic [7:0] port0_overdrive,
  output logic match_event,
  output logic match_irq,
  output logic osc_wake
);
  logic [7:0] latch [3];
  logic [7:0] next_latch [3];
  logic [7:0] kind [3];
  logic [7:0] next_kind [3];
  logic [7:0] drive [3];
  logic [7:0] next_drive [3];
  logic [7:0] skip [3];
  logic [7:0] next_skip [3];
  logic [7:0] mask [2];
  logic [7:0] next_mask [2];
  logic [7:0] value [2];
  logic [7:0] next_value [2];
  logic [7:0] ovrd;
  logic [7:0] next_ovrd;
  logic [7:0] next_rdata;
  logic [23:0] pin_meta;
  logic [23:0] pin_sync;
  logic [23:0] pin_level;
  logic [23:0] next_out;
  logic [23:0] next_oe;
  logic [23:0] next_pullup;
  logic mismatch;
  logic [23:0] next_digital;
  logic [23:0] next_bypass;
  logic next_event;
  logic next_irq;

  // port number for a latch address, 3 when none
  function automatic logic [1:0] latch_port(input logic [7:0] a);
    if (a == pio_pkg::PIO_ADDR_P0_LATCH)
      latch_port = 2'h0;
    else if (a == pio_pkg::PIO_ADDR_P1_LATCH)
      latch_port = 2'h1;
    else if (a == pio_pkg::PIO_ADDR_P2_LATCH)
      latch_port = 2'h2;
    else
      latch_port = 2'h3;
  endfunction

  always_comb
  begin
    logic [1:0] lp;
    lp = latch_port(sfr_addr);
    next_latch = latch;
    next_kind = kind;
    next_drive = drive;
    next_skip = skip;
    next_mask = mask;
    next_value = value;
    next_ovrd = ovrd;
    if (sfr_wr)
    begin
      if (lp != 2'h3)
        next_latch[lp] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_KIND)
        next_kind[0] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_KIND)
        next_kind[1] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P2_KIND)
        next_kind[2] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_DRIVE)
        next_drive[0] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_DRIVE)
        next_drive[1] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P2_DRIVE)
        next_drive[2] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_SKIP)
        next_skip[0] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_SKIP)
        next_skip[1] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P2_SKIP)
        next_skip[2] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_MASK)
        next_mask[0] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_MASK)
        next_mask[1] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_VALUE)
        next_value[0] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_VALUE)
        next_value[1] = sfr_wdata;
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_OVRD)
        next_ovrd = sfr_wdata;
    end
    else if (sfr_bit_wr && lp != 2'h3)
      next_latch[lp][sfr_bit_num] = sfr_bit_val;
  end

  always_comb
  begin
    logic [1:0] lp;
    lp = latch_port(sfr_addr);
    next_rdata = 8'h00;
    if (sfr_rd)
    begin
      if (lp != 2'h3 && sfr_rmw)
        next_rdata = latch[lp];
      else if (lp == 2'h0)
        next_rdata = pin_level[7:0];
      else if (lp == 2'h1)
        next_rdata = pin_level[15:8];
      else if (lp == 2'h2)
        next_rdata = pin_level[23:16];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_KIND)
        next_rdata = kind[0];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_KIND)
        next_rdata = kind[1];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P2_KIND)
        next_rdata = kind[2];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_DRIVE)
        next_rdata = drive[0];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_DRIVE)
        next_rdata = drive[1];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P2_DRIVE)
        next_rdata = drive[2];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_SKIP)
        next_rdata = skip[0];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_SKIP)
        next_rdata = skip[1];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P2_SKIP)
        next_rdata = skip[2];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_MASK)
        next_rdata = mask[0];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_MASK)
        next_rdata = mask[1];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_VALUE)
        next_rdata = value[0];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P1_VALUE)
        next_rdata = value[1];
      else if (sfr_addr == pio_pkg::PIO_ADDR_P0_OVRD)
        next_rdata = ovrd;
    end
  end

  // per-pin drive, pullup and readback
  genvar gi;
  generate
    for (gi = 0; gi < pio_pkg::PIO_PINS; gi++)
    begin : g_pin
      logic dig;
      logic od;
      logic dat;
      assign dig = kind[gi / 8][gi % 8];
      assign od = ~drive[gi / 8][gi % 8] | i2c_route[gi];
      assign dat = xbar_claim[gi] ? xbar_data[gi] : latch[gi / 8][gi % 8];
      assign pin_level[gi] = dig & pin_sync[gi];
      assign next_out[gi] = dat;
      assign next_oe[gi] = crossbar_on & dig & (~dat | ~od);
      assign next_pullup[gi] = ~pullup_disable & dig & od & ~(next_oe[gi] & ~dat);
    end
  endgenerate

  // masked compare on ports 0 and 1
  assign mismatch = (|((pin_level[7:0] ^ value[0]) & mask[0]))
    | (|((pin_level[15:8] ^ value[1]) & mask[1]));

  // next values of the exported configuration and match outputs
  always_comb
  begin
    next_digital = {kind[2], kind[1], kind[0]};
    next_bypass = {skip[2], skip[1], skip[0]};
    next_event = mismatch;
    next_irq = mismatch & match_irq_enable;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int p = 0; p < pio_pkg::PIO_PORTS; p++)
      begin
        latch[p] <= pio_pkg::PIO_RST_LATCH;
        kind[p] <= pio_pkg::PIO_RST_KIND;
        drive[p] <= pio_pkg::PIO_RST_DRIVE;
        skip[p] <= pio_pkg::PIO_RST_SKIP;
      end
      for (int p = 0; p < 2; p++)
      begin
        mask[p] <= pio_pkg::PIO_RST_MASK;
        value[p] <= pio_pkg::PIO_RST_VALUE;
      end
      ovrd <= pio_pkg::PIO_RST_OVRD;
    end
    else
    begin
      latch <= next_latch;
      kind <= next_kind;
      drive <= next_drive;
      skip <= next_skip;
      mask <= next_mask;
      value <= next_value;
      ovrd <= next_ovrd;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= next_rdata;
  end

  // pins change off our clock, so two flops stand before any logic reads them
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_meta <= 24'h000000;
      pin_sync <= 24'h000000;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out <= {3{pio_pkg::PIO_RST_LATCH}};
      pin_oe <= 24'h000000;
      pin_pullup <= 24'h000000;
    end
    else
    begin
      pin_out <= next_out;
      pin_oe <= next_oe;
      pin_pullup <= next_pullup;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_digital <= {3{pio_pkg::PIO_RST_KIND}};
      crossbar_bypass <= {3{pio_pkg::PIO_RST_SKIP}};
      port0_overdrive <= pio_pkg::PIO_RST_OVRD;
    end
    else
    begin
      pin_digital <= next_digital;
      crossbar_bypass <= next_bypass;
      port0_overdrive <= ovrd;
    end
  end

  // wake follows the mismatch alone, it never waits for the interrupt enable
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      match_event <= 1'b0;
      match_irq <= 1'b0;
      osc_wake <= 1'b0;
    end
    else
    begin
      match_event <= next_event;
      match_irq <= next_irq;
      osc_wake <= next_event;
    end
  end
endmodule

// >>> test/pio_port_asserts.sv
// pio_chk: port-level checks on the port block
// assumes one clk domain and async active-low resetn
`timescale 1ns/10ps
module pio_chk
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic crossbar_on,
  input wire logic pullup_disable,
  input wire logic match_irq_enable,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pullup,
  input wire logic [23:0] pin_digital,
  input wire logic [23:0] crossbar_bypass,
  input wire logic [7:0] port0_overdrive,
  input wire logic match_event,
  input wire logic match_irq,
  input wire logic osc_wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_off; !crossbar_on |=> pin_oe == 24'h0; endproperty
  a_off: assert property (p_off) else $error("driver on, crossbar off");
  property p_ana; ((pin_oe | pin_pullup) & ~pin_digital) == 24'h0; endproperty
  a_ana: assert property (p_ana) else $error("analog pin driven");
  property p_pd; (pin_pullup & pin_oe) == 24'h0; endproperty
  a_pd: assert property (p_pd) else $error("pullup on driven pin");
  property p_pud; pullup_disable |=> pin_pullup == 24'h0; endproperty
  a_pud: assert property (p_pud) else $error("pullup while disabled");
  property p_irq; match_irq == (match_event & $past(match_irq_enable)); endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_wake; osc_wake == match_event; endproperty
  a_wake: assert property (p_wake) else $error("wake mismatch");
  property p_rd; !sfr_rd |=> sfr_rdata == 8'h00; endproperty
  a_rd: assert property (p_rd) else $error("read data without read");
  property p_cfg; !$past(sfr_wr) && !$past(sfr_wr, 2) |-> $stable(pin_digital)
    && $stable(crossbar_bypass) && $stable(port0_overdrive); endproperty
  a_cfg: assert property (p_cfg) else $error("config moved");
endmodule
bind pio_port pio_chk i_chk (.clk(clk), .resetn(resetn), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .crossbar_on(crossbar_on), .pullup_disable(pullup_disable),
  .match_irq_enable(match_irq_enable), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
  .pin_digital(pin_digital), .crossbar_bypass(crossbar_bypass),
  .port0_overdrive(port0_overdrive), .match_event(match_event), .match_irq(match_irq),
  .osc_wake(osc_wake));

// >>> test/pio_pins.sv
// pio_pins: external pins seen by the port block
// assumes the block wins over an outside driver on the same pin
`timescale 1ns/10ps
module pio_pins
(
  input wire logic clk,
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pullup,
  input wire logic [23:0] ext_en,
  input wire logic [23:0] ext_val,
  output logic [23:0] pin_in
);
  logic [23:0] flt = 24'h5A5A5A;
  // an undriven pin without pullup wanders
  always_ff @(posedge clk) flt <= ~flt;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | flt));
endmodule

// >>> test/pio_port_test.sv
// pio_port_test: register, pin and match scenarios for the port block
// assumes pio_pins on the pins and pio_chk bound to the block
`timescale 1ns/10ps
module pio_port_test;
  logic clk = 1'h0, resetn = 1'h0, sfr_wr = 1'h0, sfr_bit_wr = 1'h0, sfr_bit_val = 1'h0;
  logic sfr_rd = 1'h0, sfr_rmw = 1'h0, crossbar_on = 1'h0, pullup_disable = 1'h0;
  logic match_irq_enable = 1'h0, match_event, match_irq, osc_wake;
  logic [2:0] sfr_bit_num = 3'h0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, port0_overdrive;
  logic [23:0] xbar_claim = 24'h0, xbar_data = 24'h0, i2c_route = 24'h0, ext_en = 24'h0;
  logic [23:0] ext_val = 24'h0, pin_in, pin_out, pin_oe, pin_pullup, pin_digital;
  logic [23:0] crossbar_bypass;
  logic [7:0] ra [18] = '{8'h80, 8'h90, 8'hA0, 8'hA4, 8'hA5, 8'hA6, 8'hB0, 8'hC7, 8'hCD,
    8'hCE, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hF1, 8'hF2, 8'hF3, 8'h81};
  logic [7:0] rv [18] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  wire [2:0] mo = {match_event, match_irq, osc_wake};
  int bad_count = 0, total_checks = 0, cycles = 0, i;
  pio_port i_dut (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_bit_wr(sfr_bit_wr), .sfr_bit_num(sfr_bit_num),
    .sfr_bit_val(sfr_bit_val), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
    .crossbar_on(crossbar_on), .pullup_disable(pullup_disable),
    .match_irq_enable(match_irq_enable), .xbar_claim(xbar_claim), .xbar_data(xbar_data),
    .i2c_route(i2c_route), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .pin_digital(pin_digital), .crossbar_bypass(crossbar_bypass),
    .port0_overdrive(port0_overdrive), .match_event(match_event), .match_irq(match_irq),
    .osc_wake(osc_wake));
  pio_pins i_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    tick(1);
    sfr_wr = 1'h0;
    tick(1);
  endtask
  task automatic bw(input logic [7:0] a, input logic [2:0] n, input logic v);
    sfr_addr = a;
    sfr_bit_num = n;
    sfr_bit_val = v;
    sfr_bit_wr = 1'h1;
    tick(1);
    sfr_bit_wr = 1'h0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
    sfr_addr = a;
    sfr_rmw = m;
    sfr_rd = 1'h1;
    tick(1);
    sfr_rd = 1'h0;
    sfr_rmw = 1'h0;
    chk(sfr_rdata, e);
    tick(1);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      wrap_up;
    end
  end
  initial
  begin
    tick(4);
    resetn = 1'h1;
    for (i = 0; i < 18; i++)
    begin
      rd(ra[i], 1'h1, rv[i]);
      wr(ra[i], rv[i] ^ 8'hA5);
      rd(ra[i], 1'h1, i < 17 ? rv[i] ^ 8'hA5 : 8'h00);
      wr(ra[i], rv[i]);
    end
    crossbar_on = 1'h1;
    i2c_route = 24'h000004;
    xbar_claim = 24'h000002;
    xbar_data = 24'h000002;
    wr(8'hA4, 8'hFF);
    wr(8'h80, 8'h3C);
    wr(8'h90, 8'h0F);
    chk(pin_oe, 24'h00F0FB);
    chk(pin_out & pin_oe, 24'h00003A);
    chk(pin_pullup, 24'hFF0F04);
    rd(8'h80, 1'h0, 8'h3E);
    rd(8'h80, 1'h1, 8'h3C);
    wr(8'hD5, 8'h03);
    wr(8'hB0, 8'h81);
    chk({crossbar_bypass, port0_overdrive}, 32'h00030081);
    crossbar_on = 1'h0;
    tick(2);
    chk(pin_oe, 24'h0);
    crossbar_on = 1'h1;
    ext_en = 24'hFF0000;
    ext_val = 24'h960000;
    wr(8'hF3, 8'h0F);
    wr(8'hD6, 8'hF0);
    rd(8'hA0, 1'h0, 8'h06);
    chk(crossbar_bypass[23:16], 8'hF0);
    chk({pin_digital[23:16], pin_pullup[23:16]}, 16'h0F0F);
    bw(8'hA0, 3'h0, 1'h0);
    rd(8'hA0, 1'h1, 8'hFE);
    chk({pin_oe[23:16], pin_pullup[23:16]}, 16'h010E);
    crossbar_on = 1'h0;
    match_irq_enable = 1'h1;
    ext_en = 24'hFFFFFF;
    ext_val = 24'h000505;
    wr(8'hC7, 8'h0F);
    wr(8'hD7, 8'h05);
    tick(4);
    chk(mo, 3'h0);
    ext_val = 24'h0005F5;
    tick(4);
    chk(mo, 3'h0);
    ext_val = 24'h0005F4;
    tick(4);
    chk(mo, 3'h7);
    match_irq_enable = 1'h0;
    tick(2);
    chk(mo, 3'h5);
    ext_val = 24'h0005F5;
    tick(4);
    chk(mo, 3'h0);
    wr(8'hCD, 8'h01);
    ext_val = 24'h0004F5;
    tick(4);
    chk(mo, 3'h5);
    wrap_up;
  end
endmodule
